//--- shared/t2r_pkg.sv
// Package of constants for the timer 2 count, reload and interrupt flag block.
// Assumes an 8-bit special function register bus with byte addresses.
package t2r_pkg;

    // Register addresses.
    localparam logic [7:0] ADDR_IEN_PRI = 8'hA8;
    localparam logic [7:0] ADDR_IEN_SEC = 8'hB8;
    localparam logic [7:0] ADDR_IRQ_FLAGS = 8'hC0;
    localparam logic [7:0] ADDR_RELOAD_LO = 8'hCA;
    localparam logic [7:0] ADDR_RELOAD_HI = 8'hCB;
    localparam logic [7:0] ADDR_COUNT_LO = 8'hCC;
    localparam logic [7:0] ADDR_COUNT_HI = 8'hCD;

    // Field positions.
    localparam int TMR_IRQ_EN_BIT = 5;
    localparam int EXT_RELOAD_EN_BIT = 7;
    localparam int EXT_RELOAD_FLAG_BIT = 7;
    localparam int OVERFLOW_FLAG_BIT = 6;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Counter limits.
    localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;
    localparam logic [15:0] COUNT_ONE = 16'h0001;

    // Read data for an unmapped address.
    localparam logic [7:0] UNMAPPED_DATA = 8'h00;

endpackage

//--- logic/t2r_timer.sv
// Timer 2 count, shared reload/compare/capture register and interrupt flags.
// Assumes a synchronous CPU register port and count ticks from outside logic.
// Two small helpers after the main module merge byte writes and flag updates.
//
// Summary of operation
// - Count low byte reads and writes live counter.
// - Count high byte reads and writes live counter.
// - Reload low byte holds reload bits 7..0.
// - Reload high byte completes reload value.
// - Reload register is also compare and capture.
// - Timer interrupt enable gates all requests.
// - External reload enable gates flag source.
// - Pin reload happens regardless of that enable.
// - Falling pin edge sets flag when enabled.
// - External flag with enable requests interrupt.
// - Pin edge flag works without reload mode.
// - External flag cleared only by software.
// - Overflow sets sticky overflow flag.
// - Overflow flag with enable requests interrupt.
// - Rollover counts as overflow in every mode.
// - Both flags share one interrupt line.
`timescale 1ns/1ps

module t2r_timer #(
    parameter int CNT_W = 16
) (
    // Clock, reset and clock enable.
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,

    // Register port.
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [7:0] rd_data_o,

    // Count source and mode controls from surrounding logic.
    input wire logic count_tick_i,
    input wire logic ovf_reload_en_i,
    input wire logic pin_reload_en_i,
    input wire logic capture_i,

    // External reload pin.
    input wire logic reload_trigger_pin_i,

    // Timer state and compare result.
    output logic [CNT_W-1:0] count_o,
    output logic [CNT_W-1:0] reload_o,
    output logic cmp_match_o,

    // Interrupt request.
    output logic tmr_irq_o
);

    typedef struct packed {
        logic [7:0] ien_pri;
        logic [7:0] ien_sec;
        logic [7:0] irq_flags;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] reload;
        logic pin_prev;
        logic reload_pend;
        logic cmp_match;
        logic [7:0] rd_data;
    } t2r_state_s;

    t2r_state_s state_q;
    t2r_state_s state_d;

    logic wr_ien_pri;
    logic wr_ien_sec;
    logic wr_flags;
    logic wr_rel_lo;
    logic wr_rel_hi;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic pin_fall;
    logic overflow;
    logic ext_set;
    logic ovf_set;
    logic [CNT_W-1:0] count_inc;
    logic [7:0] rd_mux;

    // Named control bits, reload requests and merged next values.
    logic tmr_irq_en;
    logic ext_reload_en;
    logic ext_flag;
    logic ovf_flag;
    logic pin_reload;
    logic ovf_reload;
    logic ext_flag_nxt;
    logic ovf_flag_nxt;
    logic [7:0] flags_sw;
    logic [CNT_W-1:0] count_hw;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] reload_hw;
    logic [CNT_W-1:0] reload_nxt;

    // One write strobe per register; an unmapped write selects none.
    always_comb begin
        wr_ien_pri = 1'b0;
        wr_ien_sec = 1'b0;
        wr_flags = 1'b0;
        wr_rel_lo = 1'b0;
        wr_rel_hi = 1'b0;
        wr_cnt_lo = 1'b0;
        wr_cnt_hi = 1'b0;
        if (wr_en_i) begin
            unique case (addr_i)
                t2r_pkg::ADDR_IEN_PRI: begin
                    wr_ien_pri = 1'b1;
                end
                t2r_pkg::ADDR_IEN_SEC: begin
                    wr_ien_sec = 1'b1;
                end
                t2r_pkg::ADDR_IRQ_FLAGS: begin
                    wr_flags = 1'b1;
                end
                t2r_pkg::ADDR_RELOAD_LO: begin
                    wr_rel_lo = 1'b1;
                end
                t2r_pkg::ADDR_RELOAD_HI: begin
                    wr_rel_hi = 1'b1;
                end
                t2r_pkg::ADDR_COUNT_LO: begin
                    wr_cnt_lo = 1'b1;
                end
                t2r_pkg::ADDR_COUNT_HI: begin
                    wr_cnt_hi = 1'b1;
                end
                default: begin
                    wr_ien_pri = 1'b0;
                end
            endcase
        end
    end

    // Falling edge seen between the previous and the present sample.
    assign pin_fall = state_q.pin_prev && !reload_trigger_pin_i;

    // Rollover from all ones, whatever drives the tick.
    assign overflow = count_tick_i && (state_q.count == CNT_W'(t2r_pkg::COUNT_ALL_ONES));
    assign count_inc = state_q.count + CNT_W'(t2r_pkg::COUNT_ONE);

    // Flag set only when the enable is high; the reload itself is not gated.
    assign ext_set = state_q.reload_pend
        && ext_reload_en;
    assign ovf_set = overflow;

    // Control and status bits used by the interrupt path.
    assign tmr_irq_en = state_q.ien_pri[t2r_pkg::TMR_IRQ_EN_BIT];
    assign ext_reload_en = state_q.ien_sec[t2r_pkg::EXT_RELOAD_EN_BIT];
    assign ext_flag = state_q.irq_flags[t2r_pkg::EXT_RELOAD_FLAG_BIT];
    assign ovf_flag = state_q.irq_flags[t2r_pkg::OVERFLOW_FLAG_BIT];

    // Reload requests from the two sources.
    assign ovf_reload = overflow && ovf_reload_en_i;
    assign pin_reload = state_q.reload_pend && pin_reload_en_i;

    always_comb begin
        rd_mux = t2r_pkg::UNMAPPED_DATA;
        unique case (addr_i)
            t2r_pkg::ADDR_IEN_PRI: begin
                rd_mux = state_q.ien_pri;
            end
            t2r_pkg::ADDR_IEN_SEC: begin
                rd_mux = state_q.ien_sec;
            end
            t2r_pkg::ADDR_IRQ_FLAGS: begin
                rd_mux = state_q.irq_flags;
            end
            t2r_pkg::ADDR_RELOAD_LO: begin
                rd_mux = state_q.reload[7:0];
            end
            t2r_pkg::ADDR_RELOAD_HI: begin
                rd_mux = state_q.reload[15:8];
            end
            t2r_pkg::ADDR_COUNT_LO: begin
                rd_mux = state_q.count[7:0];
            end
            t2r_pkg::ADDR_COUNT_HI: begin
                rd_mux = state_q.count[15:8];
            end
            default: begin
                rd_mux = t2r_pkg::UNMAPPED_DATA;
            end
        endcase
    end

    always_comb begin
        state_d = state_q;

        // Read data stand in the cycle after the strobe only.
        if (rd_en_i) begin
            state_d.rd_data = rd_mux;
        end else begin
            state_d.rd_data = t2r_pkg::RST_BYTE;
        end

        // Pin sampling and reload scheduled one cycle after detection.
        state_d.pin_prev = reload_trigger_pin_i;
        state_d.reload_pend = pin_fall;

        // Enable registers.
        if (wr_ien_pri) begin
            state_d.ien_pri = wr_data_i;
        end
        if (wr_ien_sec) begin
            state_d.ien_sec = wr_data_i;
        end

        // Flag byte, counter and shared register with all updates merged.
        state_d.irq_flags = flags_sw;
        state_d.irq_flags[t2r_pkg::EXT_RELOAD_FLAG_BIT] = ext_flag_nxt;
        state_d.irq_flags[t2r_pkg::OVERFLOW_FLAG_BIT] = ovf_flag_nxt;
        state_d.count = count_nxt;
        state_d.reload = reload_nxt;
        state_d.cmp_match = (state_q.count == state_q.reload);
    end

    // Counter after ticks and reloads, before software byte writes.
    always_comb begin
        count_hw = state_q.count;
        if (count_tick_i) begin
            count_hw = count_inc;
        end
        if (ovf_reload) begin
            count_hw = state_q.reload;
        end
        if (pin_reload) begin
            count_hw = state_q.reload;
        end
    end

    // Shared register after a capture, before software byte writes.
    always_comb begin
        reload_hw = state_q.reload;
        if (capture_i) begin
            reload_hw = state_q.count;
        end
    end

    // Flag byte after a software write; other bits are plain storage.
    always_comb begin
        flags_sw = state_q.irq_flags;
        if (wr_flags) begin
            flags_sw = wr_data_i;
        end
    end

    // Software byte writes win over every hardware update.
    t2r_lane_write #(
        .W(CNT_W)
    ) u_count_wr (
        .cur_i(count_hw),
        .wr_lo_i(wr_cnt_lo),
        .wr_hi_i(wr_cnt_hi),
        .data_i(wr_data_i),
        .val_o(count_nxt)
    );

    t2r_lane_write #(
        .W(CNT_W)
    ) u_reload_wr (
        .cur_i(reload_hw),
        .wr_lo_i(wr_rel_lo),
        .wr_hi_i(wr_rel_hi),
        .data_i(wr_data_i),
        .val_o(reload_nxt)
    );

    // A hardware set wins over a software clear in the same cycle.
    t2r_flag_next u_ext_flag (
        .cur_i(ext_flag),
        .wr_i(wr_flags),
        .wr_val_i(wr_data_i[t2r_pkg::EXT_RELOAD_FLAG_BIT]),
        .set_i(ext_set),
        .flag_o(ext_flag_nxt)
    );

    t2r_flag_next u_ovf_flag (
        .cur_i(ovf_flag),
        .wr_i(wr_flags),
        .wr_val_i(wr_data_i[t2r_pkg::OVERFLOW_FLAG_BIT]),
        .set_i(ovf_set),
        .flag_o(ovf_flag_nxt)
    );

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q.ien_pri <= t2r_pkg::RST_BYTE;
            state_q.ien_sec <= t2r_pkg::RST_BYTE;
            state_q.irq_flags <= t2r_pkg::RST_BYTE;
            state_q.count <= CNT_W'(t2r_pkg::RST_WORD);
            state_q.reload <= CNT_W'(t2r_pkg::RST_WORD);
            state_q.pin_prev <= 1'b0;
            state_q.reload_pend <= 1'b0;
            state_q.cmp_match <= 1'b0;
            state_q.rd_data <= t2r_pkg::RST_BYTE;
        end else if (ce_i) begin
            state_q <= state_d;
        end
    end

    assign rd_data_o = state_q.rd_data;
    assign count_o = state_q.count;
    assign reload_o = state_q.reload;
    assign cmp_match_o = state_q.cmp_match;

    // One shared level request from both flags.
    assign tmr_irq_o = tmr_irq_en
        && (ext_flag
        || ovf_flag);

endmodule

// Merges byte-lane writes from the register port into a wider value.
module t2r_lane_write #(
    parameter int W = 16
) (
    // Value before the write.
    input wire logic [W-1:0] cur_i,

    // Byte lane strobes and data.
    input wire logic wr_lo_i,
    input wire logic wr_hi_i,
    input wire logic [7:0] data_i,

    // Value after the write.
    output logic [W-1:0] val_o
);

    always_comb begin
        val_o = cur_i;
        if (wr_lo_i) begin
            val_o[7:0] = data_i;
        end
        if (wr_hi_i) begin
            val_o[15:8] = data_i;
        end
    end

endmodule

// Next value of one sticky flag with software write and hardware set.
module t2r_flag_next (
    // Present value and software write.
    input wire logic cur_i,
    input wire logic wr_i,
    input wire logic wr_val_i,

    // Hardware event.
    input wire logic set_i,

    // Next value.
    output logic flag_o
);

    always_comb begin
        flag_o = cur_i;
        if (wr_i) begin
            flag_o = wr_val_i;
        end
        if (set_i) begin
            flag_o = 1'b1;
        end
    end

endmodule

//--- dv/t2r_timer_properties.sv
// Port assertions for the timer 2 count, reload and flag block.
// Assumes it is bound onto every t2r_timer instance.
`timescale 1ns/1ps
module t2r_props #(
    parameter int CNT_W = 16
) (
    // Clock and reset.
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Observed ports.
    input wire logic ce_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [7:0] rd_data_o,
    input wire logic count_tick_i,
    input wire logic ovf_reload_en_i,
    input wire logic pin_reload_en_i,
    input wire logic [CNT_W-1:0] count_o,
    input wire logic [CNT_W-1:0] reload_o,
    input wire logic tmr_irq_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    wire wr_ok = ce_i && wr_en_i;
    reset_zero_a: assert property ($past(reset_i) |-> !count_o && !reload_o && !tmr_irq_o)
        else $error("Outputs not clear after reset.");
    count_lo_a: assert property (wr_ok && addr_i == t2r_pkg::ADDR_COUNT_LO |=>
        count_o[7:0] == $past(wr_data_i)) else $error("Count low write lost.");
    count_hi_a: assert property (wr_ok && addr_i == t2r_pkg::ADDR_COUNT_HI |=>
        count_o[15:8] == $past(wr_data_i)) else $error("Count high write lost.");
    reload_lo_a: assert property (wr_ok && addr_i == t2r_pkg::ADDR_RELOAD_LO |=>
        reload_o[7:0] == $past(wr_data_i)) else $error("Reload low write lost.");
    reload_hi_a: assert property (wr_ok && addr_i == t2r_pkg::ADDR_RELOAD_HI |=>
        reload_o[15:8] == $past(wr_data_i)) else $error("Reload high write lost.");
    count_rollover_a: assert property (ce_i && count_tick_i && &count_o && !wr_en_i
        && !pin_reload_en_i && !ovf_reload_en_i |=> !count_o) else $error("No rollover.");
    irq_hold_a: assert property (tmr_irq_o && !wr_en_i |=> tmr_irq_o)
        else $error("Interrupt dropped without a write.");
    rd_idle_a: assert property ($past(ce_i) && !$past(rd_en_i) |-> rd_data_o == 8'h00)
        else $error("Read data outside its cycle.");
    cover property ($rose(tmr_irq_o));
    cover property (count_tick_i && &count_o);
    cover property (rd_en_i ##1 rd_data_o != 8'h00);
endmodule
bind t2r_timer t2r_props #(.CNT_W(CNT_W)) u_props (.core_clk_i(core_clk_i),
    .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
    .count_tick_i(count_tick_i), .ovf_reload_en_i(ovf_reload_en_i),
    .pin_reload_en_i(pin_reload_en_i), .count_o(count_o), .reload_o(reload_o),
    .tmr_irq_o(tmr_irq_o));

//--- dv/tb_top.sv
// Self-checking bench for the timer 2 count, reload and flag block.
// Assumes the checker binds itself onto the design.
`timescale 1ns/1ps
module tb_top;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic wr_en_i = 1'b0;
    logic rd_en_i = 1'b0;
    logic tick = 1'b0;
    logic pin = 1'b1;
    logic pin_mode = 1'b0;
    logic cap = 1'b0;
    logic ce = 1'b1;
    logic ovf_mode = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wr_data_i = 8'h00;
    logic [7:0] rd_data_o;
    logic [15:0] count_o;
    logic [15:0] reload_o;
    logic tmr_irq_o;
    logic cmp;
    int fail_count = 0;
    int tests_run = 0;
    t2r_timer dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce), .addr_i(addr_i),
        .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
        .count_tick_i(tick), .ovf_reload_en_i(ovf_mode), .pin_reload_en_i(pin_mode),
        .capture_i(cap), .reload_trigger_pin_i(pin), .count_o(count_o),
        .reload_o(reload_o), .cmp_match_o(cmp), .tmr_irq_o(tmr_irq_o));
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    task chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_en_i <= 1'b1;
        @(posedge core_clk_i);
        wr_en_i <= 1'b0;
        #1;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_i);
        addr_i <= a;
        rd_en_i <= 1'b1;
        @(posedge core_clk_i);
        rd_en_i <= 1'b0;
        #1 chk({8'h00, rd_data_o}, {8'h00, exp});
    endtask
    task fall;
        @(posedge core_clk_i);
        pin <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        pin <= 1'b1;
        #1;
    endtask
    task t_reset;
        for (int i = 8'hA8; i <= 8'hCD; i++) rd(8'(i), 8'h00);
    endtask
    task t_regs;
        wr(t2r_pkg::ADDR_COUNT_LO, 8'h34);
        wr(t2r_pkg::ADDR_COUNT_HI, 8'h12);
        wr(t2r_pkg::ADDR_RELOAD_LO, 8'hCD);
        wr(t2r_pkg::ADDR_RELOAD_HI, 8'hAB);
        chk(count_o, 16'h1234);
        chk(reload_o, 16'hABCD);
        rd(t2r_pkg::ADDR_COUNT_HI, 8'h12);
        rd(t2r_pkg::ADDR_RELOAD_LO, 8'hCD);
        @(posedge core_clk_i);
        cap <= 1'b1;
        @(posedge core_clk_i);
        cap <= 1'b0;
        #1 chk(reload_o, 16'h1234);
        @(posedge core_clk_i);
        #1 chk(cmp, 16'h1);
        wr(t2r_pkg::ADDR_RELOAD_HI, 8'hAB);
        wr(t2r_pkg::ADDR_RELOAD_LO, 8'hCD);
        chk(cmp, 16'h0);
    endtask
    task t_pin;
        wr(t2r_pkg::ADDR_IEN_PRI, 8'h20);
        pin_mode <= 1'b1;
        fall;
        chk(count_o, 16'hABCD);
        chk(tmr_irq_o, 16'h0);
        rd(t2r_pkg::ADDR_IRQ_FLAGS, 8'h00);
        wr(t2r_pkg::ADDR_IEN_SEC, 8'h80);
        fall;
        chk(tmr_irq_o, 16'h1);
        rd(t2r_pkg::ADDR_IRQ_FLAGS, 8'h80);
        rd(t2r_pkg::ADDR_IRQ_FLAGS, 8'h80);
        wr(t2r_pkg::ADDR_IRQ_FLAGS, 8'h00);
        chk(tmr_irq_o, 16'h0);
        pin_mode <= 1'b0;
        wr(t2r_pkg::ADDR_COUNT_LO, 8'h11);
        fall;
        chk(count_o, 16'hAB11);
        chk(tmr_irq_o, 16'h1);
        wr(t2r_pkg::ADDR_IRQ_FLAGS, 8'h00);
    endtask
    task t_ovf;
        wr(t2r_pkg::ADDR_COUNT_LO, 8'hFF);
        wr(t2r_pkg::ADDR_COUNT_HI, 8'hFF);
        @(posedge core_clk_i);
        tick <= 1'b1;
        @(posedge core_clk_i);
        tick <= 1'b0;
        #1 chk(count_o, 16'h0000);
        chk(tmr_irq_o, 16'h1);
        wr(t2r_pkg::ADDR_IEN_PRI, 8'h00);
        chk(tmr_irq_o, 16'h0);
        rd(t2r_pkg::ADDR_IRQ_FLAGS, 8'h40);
        wr(t2r_pkg::ADDR_IEN_PRI, 8'h20);
        wr(t2r_pkg::ADDR_IRQ_FLAGS, 8'h00);
        chk(tmr_irq_o, 16'h0);
        wr(t2r_pkg::ADDR_IRQ_FLAGS, 8'h80);
        chk(tmr_irq_o, 16'h1);
        wr(t2r_pkg::ADDR_COUNT_LO, 8'hFF);
        wr(t2r_pkg::ADDR_COUNT_HI, 8'hFF);
        @(posedge core_clk_i);
        tick <= 1'b1;
        ovf_mode <= 1'b1;
        @(posedge core_clk_i);
        tick <= 1'b0;
        ovf_mode <= 1'b0;
        #1 chk(count_o, 16'hABCD);
        rd(t2r_pkg::ADDR_IRQ_FLAGS, 8'hC0);
    endtask
    task t_ce;
        @(posedge core_clk_i);
        ce <= 1'b0;
        tick <= 1'b1;
        addr_i <= t2r_pkg::ADDR_COUNT_LO;
        wr_data_i <= 8'h55;
        wr_en_i <= 1'b1;
        @(posedge core_clk_i);
        wr_en_i <= 1'b0;
        @(posedge core_clk_i);
        ce <= 1'b1;
        tick <= 1'b0;
        #1 chk(count_o, 16'hABCD);
    endtask
    task t_rst_again;
        @(posedge core_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        reset_i <= 1'b0;
        #1 chk(count_o, 16'h0000);
        chk(tmr_irq_o, 16'h0);
        t_reset;
    endtask
    task print_verdict;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        t_reset;
        t_regs;
        t_pin;
        t_ovf;
        t_ce;
        t_rst_again;
        print_verdict;
    end
endmodule
